// ===== src/lookup_mux_params.svh
// Constants for the layer-2 lookup channel multiplexers
// What this block does
// R1: Per frame, build VLAN, MAC key and filter-ID channels under 32 profiles.
// R2: Destination key picks parsed, next-hop, multicast, IP dest, IP source, constant.
// R3: Multicast key: low 24 bits copied, upper from bits 63:40 with U/L toggled.
// R4: Source key picks parsed source, IP source 95:48, undefined slot, or constant.
// R5: Four 12-bit filter IDs from VLANs, classifier slices or next-hop fields.
// R6: VLAN channels pick parsed VLANs, next-hop or classifier words; swap allowed.
// R7: Port-group tag is a masked combine; source 0 is the link source tag.
// R8: Port-group tag may also come from layer-3 hash or tag transform output.
// R9: Undefined sources drive zeros on their channel.
`ifndef LOOKUP_MUX_PARAMS_SVH
`define LOOKUP_MUX_PARAMS_SVH
`define PROFILE_COUNT 32
`define PIPE_LATENCY 1
`define DMAC_SEL_PARSED 3'h0
`define DMAC_SEL_NEXTHOP 3'h1
`define DMAC_SEL_MCAST 3'h2
`define DMAC_SEL_IPDST 3'h3
`define DMAC_SEL_IPSRC 3'h4
`define DMAC_SEL_CONST 3'h7
`define SMAC_SEL_PARSED 2'h0
`define SMAC_SEL_IPSRC 2'h1
`define SMAC_SEL_CONST 2'h3
`define FID_SEL_VLAN 2'h0
`define FID_SEL_CLASS 2'h1
`define FID_SEL_NEXTHOP 2'h2
`define VID_SEL_FIRST 3'h0
`define VID_SEL_SECOND 3'h1
`define VID_SEL_NH_A 3'h2
`define VID_SEL_CLS_A 3'h3
`define VID_SEL_CLS_B 3'h4
`define VID_SEL_NH_B 3'h5
`define MCAST_UL_TOGGLE 24'h020000
`define MCAST_LOW_MSB 23
`define MCAST_HIGH_MSB 63
`define MCAST_HIGH_LSB 40
`define IPSRC_SMAC_MSB 95
`define IPSRC_SMAC_LSB 48
`define CLS_SPLIT 12
`endif

// ===== src/lookup_mux_pkg.sv
// Types shared by the lookup channel multiplexers
package lookup_mux_pkg;
  typedef logic [11:0] vid_t;
  typedef logic [47:0] mac_t;

  typedef struct packed {
    mac_t parsed_destination_mac;
    mac_t parsed_source_mac;
    vid_t parsed_vlan_a;
    vid_t parsed_vlan_b;
    logic [127:0] ip_destination;
    logic [127:0] ip_source;
    logic [15:0] nh_w16a;
    logic [15:0] nh_w16b;
    logic [15:0] nh_w16c;
    logic [11:0] nh_w12a;
    logic [11:0] nh_w12b;
    logic [15:0] cls_w16a;
    logic [15:0] cls_w16b;
    logic [15:0] classifier_field_low;
    logic [15:0] classifier_field_high;
    logic [15:0] link_src_port_tag;
    logic [15:0] layer3_hash_value;
    logic [15:0] transformed_port_tag;
  } frame_s;

  typedef struct packed {
    logic [2:0] dmac_sel;
    mac_t dmac_const;
    logic [1:0] smac_sel;
    mac_t smac_const;
    logic [1:0] fid_src_a_sel;
    logic [1:0] fid_src_b_sel;
    logic [1:0] fid_dst_a_sel;
    logic [1:0] fid_dst_b_sel;
    logic [2:0] ivid_a_sel;
    logic [2:0] ivid_b_sel;
    logic [2:0] evid_a_sel;
    logic [2:0] evid_b_sel;
    logic [15:0] tag_mask_link;
    logic [15:0] tag_mask_hash;
    logic [15:0] tag_mask_xform;
  } profile_s;

  typedef struct packed {
    mac_t dest_mac_key;
    mac_t src_mac_key;
    vid_t src_key_filter_id_a;
    vid_t src_key_filter_id_b;
    vid_t dst_key_filter_id_a;
    vid_t dst_key_filter_id_b;
    vid_t ingress_vlan_a;
    vid_t ingress_vlan_b;
    vid_t egress_vlan_a;
    vid_t egress_vlan_b;
    logic [15:0] canonical_src_port_tag;
  } lookup_s;
endpackage

// ===== src/vlan_select.sv
// One VLAN ID channel selector
`timescale 1ns/10ps
`include "lookup_mux_params.svh"
module vlan_select
  import lookup_mux_pkg::*;
#(
  parameter bit HAS_NH_B = 1'b0
) (
  input wire logic [2:0] sel,
  input wire vid_t first,
  input wire vid_t second,
  input wire vid_t nh_a,
  input wire vid_t nh_b,
  input wire vid_t cls_a,
  input wire vid_t cls_b,
  output vid_t vid
);
  // Source pick; swapped first/second lets the parser order be undone
  always_comb begin
    case (sel)
      // R6: VLAN sources
      `VID_SEL_FIRST: vid = first;
      `VID_SEL_SECOND: vid = second;
      `VID_SEL_NH_A: vid = nh_a;
      `VID_SEL_CLS_A: vid = cls_a;
      `VID_SEL_CLS_B: vid = cls_b;
      `VID_SEL_NH_B: vid = HAS_NH_B ? nh_b : 12'h000;
      // R9: undefined gives zero
      default: vid = 12'h000;
    endcase
  end
endmodule

// ===== src/l3_action_resolver.sv
// Lookup channel multiplexers of the layer-3 action resolver
`timescale 1ns/10ps
`include "lookup_mux_params.svh"
module l3_action_resolver
  import lookup_mux_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic CFG_WRITE,
  input wire logic [4:0] CFG_INDEX,
  input wire profile_s CFG_DATA,
  input wire logic FRAME_VALID,
  input wire logic [4:0] PROFILE,
  input wire frame_s FRAME,
  output logic OUT_VALID,
  output lookup_s OUT_CHANNELS
);
  profile_s table_r [`PROFILE_COUNT];
  profile_s cfg;
  lookup_s chan_nxt;
  lookup_s chan_r;
  logic valid_r;
  logic valid_nxt;
  mac_t mcast_key;
  logic [31:0] cls_field;
  vid_t ivid_a;
  vid_t ivid_b;
  vid_t evid_a;
  vid_t evid_b;
  vid_t cls_a;
  vid_t cls_b;

  // R1: profile table, one entry per profile
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      for (int i = 0; i < `PROFILE_COUNT; i++) begin
        table_r[i] <= '0;
      end
    end else if (CFG_WRITE) begin
      table_r[CFG_INDEX] <= CFG_DATA;
    end
  end

  // Shared source slices
  always_comb begin
    cfg = table_r[PROFILE];
    cls_field = {FRAME.classifier_field_high, FRAME.classifier_field_low};
    cls_a = FRAME.cls_w16a[11:0];
    cls_b = FRAME.cls_w16b[11:0];
    // R3: EUI-64 derived key with U/L flag toggled
    mcast_key[`MCAST_LOW_MSB:0] = FRAME.ip_destination[`MCAST_LOW_MSB:0];
    mcast_key[47:24] = FRAME.ip_destination[`MCAST_HIGH_MSB:`MCAST_HIGH_LSB]
      ^ `MCAST_UL_TOGGLE;
  end

  // R6: four VLAN channels, second ones see the VLANs swapped
  vlan_select #(.HAS_NH_B(1'b0)) u_ivid_a (
    .sel(cfg.ivid_a_sel), .first(FRAME.parsed_vlan_a),
    .second(FRAME.parsed_vlan_b), .nh_a(FRAME.nh_w12a),
    .nh_b(FRAME.nh_w12b), .cls_a(cls_a), .cls_b(cls_b), .vid(ivid_a)
  );
  vlan_select #(.HAS_NH_B(1'b0)) u_ivid_b (
    .sel(cfg.ivid_b_sel), .first(FRAME.parsed_vlan_b),
    .second(FRAME.parsed_vlan_a), .nh_a(FRAME.nh_w12a),
    .nh_b(FRAME.nh_w12b), .cls_a(cls_a), .cls_b(cls_b), .vid(ivid_b)
  );
  vlan_select #(.HAS_NH_B(1'b0)) u_evid_a (
    .sel(cfg.evid_a_sel), .first(FRAME.parsed_vlan_a),
    .second(FRAME.parsed_vlan_b), .nh_a(FRAME.nh_w12a),
    .nh_b(FRAME.nh_w12b), .cls_a(cls_a), .cls_b(cls_b), .vid(evid_a)
  );
  vlan_select #(.HAS_NH_B(1'b1)) u_evid_b (
    .sel(cfg.evid_b_sel), .first(FRAME.parsed_vlan_b),
    .second(FRAME.parsed_vlan_a), .nh_a(FRAME.nh_w12a),
    .nh_b(FRAME.nh_w12b), .cls_a(cls_a), .cls_b(cls_b), .vid(evid_b)
  );

  // Next values of all output channels
  always_comb begin
    chan_nxt = chan_r;
    valid_nxt = FRAME_VALID;
    if (FRAME_VALID) begin
      // R2: destination key sources
      case (cfg.dmac_sel)
        `DMAC_SEL_PARSED: chan_nxt.dest_mac_key = FRAME.parsed_destination_mac;
        `DMAC_SEL_NEXTHOP:
          chan_nxt.dest_mac_key = {FRAME.nh_w16c, FRAME.nh_w16b, FRAME.nh_w16a};
        `DMAC_SEL_MCAST: chan_nxt.dest_mac_key = mcast_key;
        `DMAC_SEL_IPDST: chan_nxt.dest_mac_key = FRAME.ip_destination[47:0];
        `DMAC_SEL_IPSRC: chan_nxt.dest_mac_key = FRAME.ip_source[47:0];
        `DMAC_SEL_CONST: chan_nxt.dest_mac_key = cfg.dmac_const;
        // R9: undefined gives zero
        default: chan_nxt.dest_mac_key = 48'h000000000000;
      endcase
      // R4: source key sources
      case (cfg.smac_sel)
        `SMAC_SEL_PARSED: chan_nxt.src_mac_key = FRAME.parsed_source_mac;
        `SMAC_SEL_IPSRC: chan_nxt.src_mac_key =
          FRAME.ip_source[`IPSRC_SMAC_MSB:`IPSRC_SMAC_LSB];
        `SMAC_SEL_CONST: chan_nxt.src_mac_key = cfg.smac_const;
        // R9: undefined gives zero
        default: chan_nxt.src_mac_key = 48'h000000000000;
      endcase
      // R5: filter IDs, undefined slots zero
      case (cfg.fid_src_a_sel)
        `FID_SEL_VLAN: chan_nxt.src_key_filter_id_a = ivid_a;
        `FID_SEL_CLASS: chan_nxt.src_key_filter_id_a = cls_field[11:0];
        default: chan_nxt.src_key_filter_id_a = 12'h000;
      endcase
      case (cfg.fid_src_b_sel)
        `FID_SEL_VLAN: chan_nxt.src_key_filter_id_b = ivid_b;
        `FID_SEL_CLASS: chan_nxt.src_key_filter_id_b = cls_field[23:12];
        default: chan_nxt.src_key_filter_id_b = 12'h000;
      endcase
      case (cfg.fid_dst_a_sel)
        `FID_SEL_VLAN: chan_nxt.dst_key_filter_id_a = evid_a;
        `FID_SEL_CLASS: chan_nxt.dst_key_filter_id_a = cls_field[11:0];
        `FID_SEL_NEXTHOP: chan_nxt.dst_key_filter_id_a = FRAME.nh_w16a[11:0];
        default: chan_nxt.dst_key_filter_id_a = 12'h000;
      endcase
      case (cfg.fid_dst_b_sel)
        `FID_SEL_VLAN: chan_nxt.dst_key_filter_id_b = evid_b;
        `FID_SEL_CLASS: chan_nxt.dst_key_filter_id_b = cls_field[23:12];
        `FID_SEL_NEXTHOP: chan_nxt.dst_key_filter_id_b = FRAME.nh_w12a;
        default: chan_nxt.dst_key_filter_id_b = 12'h000;
      endcase
      chan_nxt.ingress_vlan_a = ivid_a;
      chan_nxt.ingress_vlan_b = ivid_b;
      chan_nxt.egress_vlan_a = evid_a;
      chan_nxt.egress_vlan_b = evid_b;
      // R7: masked combine of link tag; R8: hash and transform sources
      chan_nxt.canonical_src_port_tag =
        (FRAME.link_src_port_tag & cfg.tag_mask_link)
        | (FRAME.layer3_hash_value & cfg.tag_mask_hash)
        | (FRAME.transformed_port_tag & cfg.tag_mask_xform);
    end
  end

  // Output stage
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      chan_r <= '0;
      valid_r <= 1'b0;
    end else begin
      chan_r <= chan_nxt;
      valid_r <= valid_nxt;
    end
  end

  assign OUT_VALID = valid_r;
  assign OUT_CHANNELS = chan_r;

  valid_follow_a: assert property ( // R1
    @(posedge CLK_SYS) disable iff (RST)
    FRAME_VALID |=> OUT_VALID)
    else $error("output valid missing one cycle after frame");

  dmac_parsed_a: assert property ( // R2
    @(posedge CLK_SYS) disable iff (RST)
    FRAME_VALID && cfg.dmac_sel == `DMAC_SEL_PARSED
    |=> OUT_CHANNELS.dest_mac_key == $past(FRAME.parsed_destination_mac))
    else $error("destination key not the parsed address");

  dmac_mcast_a: assert property ( // R3
    @(posedge CLK_SYS) disable iff (RST)
    FRAME_VALID && cfg.dmac_sel == `DMAC_SEL_MCAST
    |=> OUT_CHANNELS.dest_mac_key[47:24] ==
        ($past(FRAME.ip_destination[63:40]) ^ 24'h020000)
        && OUT_CHANNELS.dest_mac_key[23:0] ==
        $past(FRAME.ip_destination[23:0]))
    else $error("multicast derived key wrong");

  smac_ipsrc_a: assert property ( // R4
    @(posedge CLK_SYS) disable iff (RST)
    FRAME_VALID && cfg.smac_sel == `SMAC_SEL_IPSRC
    |=> OUT_CHANNELS.src_mac_key == $past(FRAME.ip_source[95:48]))
    else $error("source key not IP source upper slice");

  fid_class_a: assert property ( // R5
    @(posedge CLK_SYS) disable iff (RST)
    FRAME_VALID && cfg.fid_src_b_sel == `FID_SEL_CLASS
    |=> OUT_CHANNELS.src_key_filter_id_b ==
        {$past(FRAME.classifier_field_high[7:0]),
         $past(FRAME.classifier_field_low[15:12])})
    else $error("filter ID classifier slice wrong");

  vid_swap_a: assert property ( // R6
    @(posedge CLK_SYS) disable iff (RST)
    FRAME_VALID && cfg.ivid_b_sel == `VID_SEL_SECOND
    |=> OUT_CHANNELS.ingress_vlan_b == $past(FRAME.parsed_vlan_a))
    else $error("ingress VLAN swap wrong");

  tag_link_a: assert property ( // R7
    @(posedge CLK_SYS) disable iff (RST)
    FRAME_VALID && cfg.tag_mask_hash == 16'h0000
    && cfg.tag_mask_xform == 16'h0000
    |=> OUT_CHANNELS.canonical_src_port_tag ==
        ($past(FRAME.link_src_port_tag) & $past(cfg.tag_mask_link)))
    else $error("link tag masking wrong");

  tag_hash_a: assert property ( // R8
    @(posedge CLK_SYS) disable iff (RST)
    FRAME_VALID && cfg.tag_mask_hash == 16'hFFFF
    |=> (OUT_CHANNELS.canonical_src_port_tag & $past(FRAME.layer3_hash_value))
        == $past(FRAME.layer3_hash_value))
    else $error("hash source not passed to tag");

  undef_zero_a: assert property ( // R9
    @(posedge CLK_SYS) disable iff (RST)
    FRAME_VALID && (cfg.dmac_sel == 3'h5 || cfg.dmac_sel == 3'h6)
    |=> OUT_CHANNELS.dest_mac_key == 48'h000000000000)
    else $error("undefined destination source not zero");

  smac_undef_a: assert property ( // R9
    @(posedge CLK_SYS) disable iff (RST)
    FRAME_VALID && cfg.smac_sel == 2'h2
    |=> OUT_CHANNELS.src_mac_key == 48'h000000000000)
    else $error("undefined source key slot not zero");

  dmac_const_a: assert property ( // R2
    @(posedge CLK_SYS) disable iff (RST)
    FRAME_VALID && cfg.dmac_sel == `DMAC_SEL_CONST
    |=> OUT_CHANNELS.dest_mac_key == $past(cfg.dmac_const))
    else $error("destination key not the profile constant");

  fid_nexthop_a: assert property ( // R5
    @(posedge CLK_SYS) disable iff (RST)
    FRAME_VALID && cfg.fid_dst_a_sel == `FID_SEL_NEXTHOP
    |=> OUT_CHANNELS.dst_key_filter_id_a == $past(FRAME.nh_w16a[11:0]))
    else $error("destination filter ID not next-hop field");

  evid_nexthop_a: assert property ( // R6
    @(posedge CLK_SYS) disable iff (RST)
    FRAME_VALID && cfg.evid_b_sel == `VID_SEL_NH_B
    |=> OUT_CHANNELS.egress_vlan_b == $past(FRAME.nh_w12b))
    else $error("second egress VLAN not next-hop word");

  tag_xform_a: assert property ( // R8
    @(posedge CLK_SYS) disable iff (RST)
    FRAME_VALID && cfg.tag_mask_xform == 16'hFFFF
    |=> (OUT_CHANNELS.canonical_src_port_tag
        & $past(FRAME.transformed_port_tag))
        == $past(FRAME.transformed_port_tag))
    else $error("transform source not passed to tag");
endmodule

// ===== dv/l2_filter_sink.sv
// Far-side model: the layer-2 filtering stage taking each channel set
`timescale 1ns/10ps
module l2_filter_sink
  import lookup_mux_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic valid,
  input wire lookup_s channels,
  output lookup_s taken,
  output int taken_count
);
  // one set per frame
  // Takes the channels only in the cycle that marks them valid
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      taken <= '0;
      taken_count <= 0;
    end else if (valid) begin
      taken <= channels;
      taken_count <= taken_count + 1;
    end
  end
endmodule

// ===== dv/l3_action_resolver_bench.sv
// Self-checking bench for the lookup channel multiplexers
`timescale 1ns/10ps
module l3_action_resolver_bench
  import lookup_mux_pkg::*;
;
  logic clk_sys, rst, cfg_write, frame_valid, out_valid;
  logic [4:0] cfg_index, profile;
  profile_s cfg_data;
  frame_s frame;
  lookup_s out_channels, taken, exp_ch;
  profile_s prof_copy [32];
  logic [31:0] seed;
  int n_mismatch = 0, tests_run = 0, n_frames = 0, taken_count, cycles = 0;

  // Clock at 25 MHz
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  l3_action_resolver l3_action_resolver_inst (.CLK_SYS(clk_sys),
    .RST(rst), .CFG_WRITE(cfg_write), .CFG_INDEX(cfg_index),
    .CFG_DATA(cfg_data), .FRAME_VALID(frame_valid), .PROFILE(profile),
    .FRAME(frame), .OUT_VALID(out_valid), .OUT_CHANNELS(out_channels));
  l2_filter_sink l2_filter_sink_inst (.clk_sys(clk_sys), .rst(rst),
    .valid(out_valid), .channels(out_channels), .taken(taken),
    .taken_count(taken_count));

  // Random words from a shift register
  function automatic logic [639:0] rnd();
    logic [639:0] w;
    for (int i = 0; i < 20; i++) begin
      seed = seed[0] ? (seed >> 1) ^ 32'h80200003 : seed >> 1;
      w[i*32 +: 32] = seed;
    end
    return w;
  endfunction

  function automatic vid_t vsel(input logic [2:0] s, input vid_t p,
      input vid_t q, input frame_s f, input logic nhb);
    case (s)
      3'h0: return p;
      3'h1: return q;
      3'h2: return f.nh_w12a;
      3'h3: return f.cls_w16a[11:0];
      3'h4: return f.cls_w16b[11:0];
      3'h5: return nhb ? f.nh_w12b : 12'h000;
      default: return 12'h000;
    endcase
  endfunction

  function automatic lookup_s want_of(input profile_s p, input frame_s f);
    lookup_s e;
    logic [31:0] cf;
    cf = {f.classifier_field_high, f.classifier_field_low};
    e = '0;
    case (p.dmac_sel)
      3'h0: e.dest_mac_key = f.parsed_destination_mac;
      3'h1: e.dest_mac_key = {f.nh_w16c, f.nh_w16b, f.nh_w16a};
      3'h2: e.dest_mac_key = {f.ip_destination[63:40] ^ 24'h020000,
        f.ip_destination[23:0]};
      3'h3: e.dest_mac_key = f.ip_destination[47:0];
      3'h4: e.dest_mac_key = f.ip_source[47:0];
      3'h7: e.dest_mac_key = p.dmac_const;
      default: e.dest_mac_key = 48'h0;
    endcase
    case (p.smac_sel)
      2'h0: e.src_mac_key = f.parsed_source_mac;
      2'h1: e.src_mac_key = f.ip_source[95:48];
      2'h3: e.src_mac_key = p.smac_const;
      default: e.src_mac_key = 48'h0;
    endcase
    e.ingress_vlan_a = vsel(p.ivid_a_sel, f.parsed_vlan_a, f.parsed_vlan_b,
      f, 1'b0);
    e.ingress_vlan_b = vsel(p.ivid_b_sel, f.parsed_vlan_b, f.parsed_vlan_a,
      f, 1'b0);
    e.egress_vlan_a = vsel(p.evid_a_sel, f.parsed_vlan_a, f.parsed_vlan_b,
      f, 1'b0);
    e.egress_vlan_b = vsel(p.evid_b_sel, f.parsed_vlan_b, f.parsed_vlan_a,
      f, 1'b1);
    e.src_key_filter_id_a = p.fid_src_a_sel == 2'h0 ? e.ingress_vlan_a :
      p.fid_src_a_sel == 2'h1 ? cf[11:0] : 12'h000;
    e.src_key_filter_id_b = p.fid_src_b_sel == 2'h0 ? e.ingress_vlan_b :
      p.fid_src_b_sel == 2'h1 ? cf[23:12] : 12'h000;
    e.dst_key_filter_id_a = p.fid_dst_a_sel == 2'h0 ? e.egress_vlan_a :
      p.fid_dst_a_sel == 2'h1 ? cf[11:0] :
      p.fid_dst_a_sel == 2'h2 ? f.nh_w16a[11:0] : 12'h000;
    e.dst_key_filter_id_b = p.fid_dst_b_sel == 2'h0 ? e.egress_vlan_b :
      p.fid_dst_b_sel == 2'h1 ? cf[23:12] :
      p.fid_dst_b_sel == 2'h2 ? f.nh_w12a : 12'h000;
    e.canonical_src_port_tag = (f.link_src_port_tag & p.tag_mask_link) |
      (f.layer3_hash_value & p.tag_mask_hash) |
      (f.transformed_port_tag & p.tag_mask_xform);
    return e;
  endfunction

  // Compare and count
  task automatic check(input logic [207:0] seen, input logic [207:0] want,
      input string what);
    tests_run++;
    if (seen !== want) begin
      n_mismatch++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask

  // One cycle: present strobes, predict, then check after the edge
  task automatic tick(input logic wr, input logic fv);
    cfg_write = wr;
    frame_valid = fv;
    if (fv) exp_ch = want_of(prof_copy[profile], frame);
    if (fv) n_frames++;
    if (wr) prof_copy[cfg_index] = cfg_data;
    @(posedge clk_sys);
    #1;
    check(208'(out_valid), 208'(fv), "valid");
    check(out_channels, exp_ch, "channels");
  endtask

  // Reset for 10 cycles; table and outputs clear
  task automatic do_reset();
    cfg_write = 1'b0;
    frame_valid = 1'b0;
    rst = 1'b1;
    repeat (10) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    exp_ch = '0;
    n_frames = 0;
    foreach (prof_copy[k]) prof_copy[k] = '0;
    check(208'(out_valid), 208'h0, "valid after reset");
    check(out_channels, exp_ch, "channels after reset");
  endtask

  task automatic conclude();
    $display("compared %0d, mismatched %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Cuts a hang short
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      n_mismatch++;
      conclude();
    end
  end

  initial begin
    logic [639:0] b;
    logic [639:0] c;
    profile_s pd;
    seed = 32'h3B4FF5B4;
    cfg_index = 5'h00;
    profile = 5'h00;
    cfg_data = '0;
    frame = '0;
    do_reset();
    // Cleared table: parsed sources, zero tag
    b = rnd();
    frame = b[$bits(frame_s)-1:0];
    profile = b[636:632];
    tick(1'b0, 1'b1);
    $display("test cleared_table done");
    // Every select code, each write racing a frame on the same entry
    for (int i = 0; i < 32; i++) begin
      b = rnd();
      c = rnd();
      pd = c[$bits(profile_s)-1:0];
      {pd.dmac_sel, pd.ivid_a_sel, pd.evid_b_sel} = {3{i[2:0]}};
      {pd.smac_sel, pd.fid_src_a_sel} = {2{i[1:0]}};
      {pd.fid_dst_b_sel, pd.fid_src_b_sel} = {i[1:0], i[2:1]};
      {pd.fid_dst_a_sel, pd.ivid_b_sel} = {i[3:2], i[3:1]};
      pd.evid_a_sel = i[4:2];
      // Whole-source hash and transform masks, on for i[3] and i[4]; link mask stays random
      pd.tag_mask_hash = i[3] ? 16'hFFFF : 16'h0000;
      pd.tag_mask_xform = i[4] ? 16'hFFFF : 16'h0000;
      cfg_data = pd;
      cfg_index = i[4:0];
      profile = i[4:0];
      frame = b[$bits(frame_s)-1:0];
      tick(1'b1, 1'b1);
    end
    $display("test table_load done");
    // Each loaded profile in turn, so every select code is decoded
    for (int i = 0; i < 32; i++) begin
      b = rnd();
      frame = b[$bits(frame_s)-1:0];
      profile = i[4:0];
      tick(1'b0, 1'b1);
    end
    $display("test profile_sweep done");
    // Random frames, gaps and writes, back to back
    for (int i = 0; i < 400; i++) begin
      b = rnd();
      c = rnd();
      frame = b[$bits(frame_s)-1:0];
      cfg_data = c[$bits(profile_s)-1:0];
      {profile, cfg_index} = b[636:627];
      tick(b[626:624] == 3'h0, b[623:622] != 2'h0);
    end
    tick(1'b0, 1'b0);
    check(taken, exp_ch, "far side channels");
    check(208'(taken_count), 208'(n_frames), "far side count");
    $display("test random_traffic done");
    // Reset in mid-run clears the table again
    do_reset();
    tick(1'b0, 1'b1);
    tick(1'b0, 1'b0);
    $display("test second_reset done");
    conclude();
  end
endmodule
